// ==== inc/clxu_defs.vh ====
// Constants of the core loader and execution unit
`ifndef CLXU_DEFS_VH
`define CLXU_DEFS_VH
`define CLXU_IMAGE_LONGS 10'h1F0
`define CLXU_IMAGE_LAST 9'h1EF
`define CLXU_RAM_DEPTH 512
`define CLXU_SPR_BASE 9'h1F0
`define CLXU_SPR_PAR 9'h1F0
`define CLXU_START_PC 9'h000
`define CLXU_IMM_MAX 9'h1FF
`define CLXU_OP_HI 31
`define CLXU_OP_LO 26
`define CLXU_WR_BIT 23
`define CLXU_IMM_BIT 22
`define CLXU_DST_HI 17
`define CLXU_DST_LO 9
`define CLXU_SRC_HI 8
`define CLXU_SRC_LO 0
`define CLXU_OP_HUB 6'h03
`define CLXU_OP_JMP 6'h17
`define CLXU_OP_ADD 6'h20
`define CLXU_OP_SUB 6'h21
`define CLXU_OP_MOV 6'h28
`define CLXU_OP_AND 6'h18
`define CLXU_OP_OR 6'h1A
`define CLXU_OP_XOR 6'h1B
`define CLXU_OP_DJNZ 6'h39
`define CLXU_OP_RDB 6'h00
`define CLXU_OP_RDW 6'h01
`define CLXU_OP_RDL 6'h02
`define CLXU_HUB_CLK 3'h0
`define CLXU_HUB_ID 3'h1
`define CLXU_HUB_START 3'h2
`define CLXU_HUB_HALT 3'h3
`define CLXU_SIZE_BYTE 2'h0
`define CLXU_SIZE_WORD 2'h1
`define CLXU_SIZE_LONG 2'h2
`endif

// ==== rtl/clxu_core.v ====
// Core loader and execution unit of one processor core
// Summary of operation
// - Launch copies 496 longs from start address
// - Then init parameter register, run from 0
// - Register RAM long only; hub any size
// - Register RAM private; hub shared by all
// - Fetch, resolve operands, execute, write back
// - Advance to next register unless redirected
// - Any register writable, modified code executes
// - Destination field is 9-bit register address
// - Immediate flag selects literal or register source
// - Literal source limited to 0 through 511
// - Arithmetic result written to destination register
// - Jump target is register contents unless immediate
// - Operation sets clock mode at run time
// - Operation returns own core number
// - Operation starts or restarts numbered core
// - Operation halts numbered core
// - Decrement-and-branch jumps only when result nonzero
`timescale 1ns/10ps
`include "clxu_defs.vh"
module clxu_core
(
  // Clock and reset
  input wire sys_clk_in,
  input wire reset_in,
  // Identity and launch
  input wire [2:0] core_number_in,
  input wire launch_in,
  input wire [15:0] launch_addr_in,
  input wire [13:0] launch_par_in,
  input wire halt_in,
  // Shared main memory hub
  output reg hub_req_out,
  output reg hub_we_out,
  output reg [1:0] hub_size_out,
  output reg [15:0] hub_addr_out,
  output reg [31:0] hub_wdata_out,
  input wire hub_ack_in,
  input wire [31:0] hub_rdata_in,
  // Core control and clock mode
  output reg start_core_by_number_out,
  output reg halt_core_by_number_out,
  output reg [2:0] target_core_out,
  output reg [15:0] target_addr_out,
  output reg set_clock_mode_runtime_out,
  output reg [7:0] clock_mode_out,
  // Status
  output reg running_out,
  output reg [8:0] pc_out
);

  // ****************************************
  // States
  // ****************************************
  localparam ST_HALT = 3'h0;
  localparam ST_LOAD = 3'h1;
  localparam ST_INIT = 3'h2;
  localparam ST_FETCH = 3'h3;
  localparam ST_EXEC = 3'h4;
  localparam ST_HUBW = 3'h5;

  // ****************************************
  // Storage and state
  // ****************************************
  // Private register RAM, reachable only from this module
  reg [31:0] ram [0:`CLXU_RAM_DEPTH-1];
  reg [2:0] state;
  reg [9:0] load_cnt;
  reg [15:0] load_addr;
  reg [13:0] par;
  reg [31:0] ir;
  reg [8:0] hub_dst;
  reg [1:0] hub_sz;

  // ****************************************
  // Operand decode
  // ****************************************
  // Field slices of the held instruction
  wire [5:0] op = ir[`CLXU_OP_HI:`CLXU_OP_LO];
  wire wr_en = ir[`CLXU_WR_BIT];
  wire imm = ir[`CLXU_IMM_BIT];
  wire [8:0] dst_a = ir[`CLXU_DST_HI:`CLXU_DST_LO];
  wire [8:0] src_f = ir[`CLXU_SRC_HI:`CLXU_SRC_LO];
  wire [31:0] dst_v = ram[dst_a];
  // Literal source is zero-extended, never above 511
  wire [31:0] src_v = imm ? {23'h000000, src_f} : ram[src_f];
  wire [31:0] dec_v = dst_v - 32'h00000001;

  // ****************************************
  // Hub access decode
  // ****************************************
  // Byte, word and long hub transfers share one handshake
  wire is_mem_op = (op == `CLXU_OP_RDB) || (op == `CLXU_OP_RDW) ||
    (op == `CLXU_OP_RDL);
  // Service operations share one opcode
  wire is_hub_op = (op == `CLXU_OP_HUB);
  // Last long of the image is being accepted
  wire load_last = (load_cnt == `CLXU_IMAGE_LONGS - 10'h001);
  wire [15:0] next_load_addr = load_addr + 16'h0004;

  // ****************************************
  // Hub read data extension
  // ****************************************
  // Narrow reads land zero-extended in the low bits of a register
  reg [31:0] hub_rd_ext;
  always @*
  begin
    hub_rd_ext = hub_rdata_in;
    case (hub_sz)
      `CLXU_SIZE_BYTE:
        hub_rd_ext = {24'h000000, hub_rdata_in[7:0]};
      `CLXU_SIZE_WORD:
        hub_rd_ext = {16'h0000, hub_rdata_in[15:0]};
      default:
        hub_rd_ext = hub_rdata_in;
    endcase
  end

  reg [31:0] result;
  reg do_wr;
  reg [8:0] next_pc;

  // ****************************************
  // Execute
  // ****************************************
  always @*
  begin
    // Default: no write, step to the next register
    result = dst_v;
    do_wr = 1'b0;
    next_pc = pc_out + 9'h001;
    // Arithmetic and logic results go to the destination
    case (op)
      `CLXU_OP_ADD:
      begin
        result = dst_v + src_v;
        do_wr = wr_en;
      end
      `CLXU_OP_SUB:
      begin
        result = dst_v - src_v;
        do_wr = wr_en;
      end
      `CLXU_OP_MOV:
      begin
        result = src_v;
        do_wr = wr_en;
      end
      `CLXU_OP_AND:
      begin
        result = dst_v & src_v;
        do_wr = wr_en;
      end
      `CLXU_OP_OR:
      begin
        result = dst_v | src_v;
        do_wr = wr_en;
      end
      `CLXU_OP_XOR:
      begin
        result = dst_v ^ src_v;
        do_wr = wr_en;
      end
      // Indirect unless the immediate flag is set
      `CLXU_OP_JMP:
        next_pc = src_v[8:0];
      // Counter is written back even when the loop ends
      `CLXU_OP_DJNZ:
      begin
        result = dec_v;
        do_wr = wr_en;
        if (dec_v != 32'h00000000)
          next_pc = src_v[8:0];
      end
      default:
      begin
        result = dst_v;
      end
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      // Register RAM keeps its contents
      state <= ST_HALT;
      load_cnt <= 10'h000;
      load_addr <= 16'h0000;
      par <= 14'h0000;
      ir <= 32'h00000000;
      hub_dst <= 9'h000;
      hub_sz <= 2'h0;
      hub_req_out <= 1'b0;
      hub_we_out <= 1'b0;
      hub_size_out <= 2'h0;
      hub_addr_out <= 16'h0000;
      hub_wdata_out <= 32'h00000000;
      start_core_by_number_out <= 1'b0;
      halt_core_by_number_out <= 1'b0;
      target_core_out <= 3'h0;
      target_addr_out <= 16'h0000;
      set_clock_mode_runtime_out <= 1'b0;
      clock_mode_out <= 8'h00;
      running_out <= 1'b0;
      pc_out <= 9'h000;
    end
    else
    begin
      // Control outputs are one-cycle strobes
      start_core_by_number_out <= 1'b0;
      halt_core_by_number_out <= 1'b0;
      set_clock_mode_runtime_out <= 1'b0;
      // Launch wins over halt and restarts the load
      if (launch_in)
      begin
        state <= ST_LOAD;
        load_cnt <= 10'h000;
        load_addr <= {launch_addr_in[15:2], 2'h0};
        par <= launch_par_in;
        hub_req_out <= 1'b1;
        hub_we_out <= 1'b0;
        hub_size_out <= `CLXU_SIZE_LONG;
        hub_addr_out <= {launch_addr_in[15:2], 2'h0};
        running_out <= 1'b0;
      end
      // Halt abandons any hub request in flight
      else if (halt_in)
      begin
        state <= ST_HALT;
        hub_req_out <= 1'b0;
        running_out <= 1'b0;
      end
      else
      begin
        case (state)
          // Request stays up; the address moves on after each long
          ST_LOAD:
            if (hub_ack_in)
            begin
              // Image fills registers from 0 upward
              ram[load_cnt[8:0]] <= hub_rdata_in;
              if (load_last)
              begin
                hub_req_out <= 1'b0;
                state <= ST_INIT;
              end
              else
              begin
                load_cnt <= load_cnt + 10'h001;
                load_addr <= next_load_addr;
                hub_addr_out <= next_load_addr;
              end
            end
          // Parameter goes above the image; code starts at register 0
          ST_INIT:
          begin
            ram[`CLXU_SPR_PAR] <= {18'h00000, par};
            pc_out <= `CLXU_START_PC;
            running_out <= 1'b1;
            state <= ST_FETCH;
          end
          // Fetch reads the register as it stands now
          ST_FETCH:
          begin
            ir <= ram[pc_out];
            state <= ST_EXEC;
          end
          // Execute, write back and step; hub transfers wait for the ack
          ST_EXEC:
          begin
            if (is_hub_op)
            begin
              // Service operations selected by the low source bits
              case (src_f[2:0])
                `CLXU_HUB_CLK:
                begin
                  clock_mode_out <= dst_v[7:0];
                  set_clock_mode_runtime_out <= 1'b1;
                end
                // Own number goes straight to the destination
                `CLXU_HUB_ID:
                  ram[dst_a] <= {29'h00000000, core_number_in};
                // Start address comes from bits 19:4 of the operand
                `CLXU_HUB_START:
                begin
                  target_core_out <= dst_v[2:0];
                  target_addr_out <= dst_v[19:4];
                  start_core_by_number_out <= 1'b1;
                end
                `CLXU_HUB_HALT:
                begin
                  target_core_out <= dst_v[2:0];
                  halt_core_by_number_out <= 1'b1;
                end
                default:
                  target_core_out <= target_core_out;
              endcase
              pc_out <= next_pc;
              state <= ST_FETCH;
            end
            // Write-result clear turns a read into a hub write
            else if (is_mem_op)
            begin
              hub_req_out <= 1'b1;
              hub_we_out <= ~wr_en;
              hub_size_out <= op[1:0];
              hub_sz <= op[1:0];
              hub_addr_out <= src_v[15:0];
              hub_wdata_out <= dst_v;
              hub_dst <= dst_a;
              state <= ST_HUBW;
            end
            else
            begin
              if (do_wr)
                ram[dst_a] <= result;
              pc_out <= next_pc;
              state <= ST_FETCH;
            end
          end
          // Writes need no data back; reads land in the destination
          ST_HUBW:
            if (hub_ack_in)
            begin
              hub_req_out <= 1'b0;
              if (!hub_we_out)
                ram[hub_dst] <= hub_rd_ext;
              pc_out <= pc_out + 9'h001;
              state <= ST_FETCH;
            end
          // Halted: wait for a launch
          default:
            running_out <= 1'b0;
        endcase
      end
    end
  end

endmodule

// ==== bench/clxu_checker.sv ====
// Assertion checker of the core loader and execution unit
`timescale 1ns/10ps
module clxu_checker
(
  // Watched ports
  input wire sys_clk_in,
  input wire reset_in,
  input wire launch_in,
  input wire [15:0] launch_addr_in,
  input wire halt_in,
  input wire hub_req_out,
  input wire hub_we_out,
  input wire [1:0] hub_size_out,
  input wire [15:0] hub_addr_out,
  input wire hub_ack_in,
  input wire start_core_by_number_out,
  input wire set_clock_mode_runtime_out,
  input wire running_out,
  input wire [8:0] pc_out
);
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  a_req_hold: assert property (
    hub_req_out && !hub_ack_in && !halt_in && !launch_in |=> hub_req_out &&
    $stable(hub_addr_out)) else $error("request dropped");
  a_addr_step: assert property (
    !running_out && hub_req_out && hub_ack_in && !halt_in && !launch_in |=>
    !hub_req_out || hub_addr_out == $past(hub_addr_out) + 16'h4)
    else $error("load address step");
  a_load_long: assert property (
    !running_out && hub_req_out |-> hub_size_out == 2'h2 && !hub_we_out)
    else $error("load not long read");
  a_launch_req: assert property (
    launch_in |=> hub_req_out &&
    hub_addr_out == ($past(launch_addr_in) & 16'hFFFC))
    else $error("launch address");
  a_start_pc: assert property (
    $rose(running_out) |-> pc_out == 9'h0) else $error("start pc");
  a_halt_stop: assert property (
    halt_in && !launch_in |=> !running_out && !hub_req_out)
    else $error("halt ignored");
  a_start_pulse: assert property (
    start_core_by_number_out |=> !start_core_by_number_out)
    else $error("start pulse long");
  a_clock_pulse: assert property (
    set_clock_mode_runtime_out |=> !set_clock_mode_runtime_out)
    else $error("clock pulse long");
endmodule
bind clxu_core clxu_checker chk (.sys_clk_in, .reset_in, .launch_in,
  .launch_addr_in, .halt_in, .hub_req_out, .hub_we_out, .hub_size_out,
  .hub_addr_out, .hub_ack_in, .start_core_by_number_out,
  .set_clock_mode_runtime_out, .running_out, .pc_out);

// ==== bench/clxu_hub_model.sv ====
// Behavioural model of the shared main memory hub
`timescale 1ns/10ps
module clxu_hub_model
(
  // Request
  input wire sys_clk_in,
  input wire hub_req_in,
  input wire hub_we_in,
  input wire [15:0] hub_addr_in,
  input wire [31:0] hub_wdata_in,
  input wire [1:0] wait_in,
  // Answer
  output reg hub_ack_out,
  output reg [31:0] hub_rdata_out
);
  reg [31:0] mem [0:1023];
  reg [1:0] cnt;
  initial
  begin
    hub_ack_out = 1'b0;
    hub_rdata_out = 32'h0;
    cnt = 2'h0;
  end
  // Ack after wait_in idle cycles; data toggles unless answering a read
  always @(posedge sys_clk_in)
  begin
    hub_ack_out <= 1'b0;
    hub_rdata_out <= ~hub_rdata_out;
    cnt <= 2'h0;
    if (hub_req_in && !hub_ack_out)
    begin
      if (cnt != wait_in)
        cnt <= cnt + 2'h1;
      else
      begin
        hub_ack_out <= 1'b1;
        if (hub_we_in)
          mem[hub_addr_in[11:2]] <= hub_wdata_in;
        else
          hub_rdata_out <= mem[hub_addr_in[11:2]];
      end
    end
  end
endmodule

// ==== bench/tb_top.sv ====
// Self-checking testbench of the core loader and execution unit
`timescale 1ns/10ps
`include "clxu_defs.vh"
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg launch = 1'b0;
  reg halt = 1'b0;
  reg [1:0] wcyc = 2'h0;
  wire req, we, ack, st, hl, ck, run;
  wire [1:0] size;
  wire [15:0] addr, taddr;
  wire [31:0] wdata, rdata;
  wire [2:0] tcore;
  wire [7:0] cmode;
  wire [8:0] pc;
  integer mismatches = 0;
  integer comparisons = 0;
  integer nw = 0;
  integer i;
  reg [15:0] wa [0:15];
  reg [31:0] wd [0:15];
  reg [31:0] cap [0:2];
  always #5 clk = ~clk;
  clxu_core DUT (.sys_clk_in(clk), .reset_in(rst), .core_number_in(3'h5),
    .launch_in(launch), .launch_addr_in(16'h0100),
    .launch_par_in(14'h1A5C), .halt_in(halt), .hub_req_out(req),
    .hub_we_out(we), .hub_size_out(size), .hub_addr_out(addr),
    .hub_wdata_out(wdata), .hub_ack_in(ack), .hub_rdata_in(rdata),
    .start_core_by_number_out(st), .halt_core_by_number_out(hl),
    .target_core_out(tcore), .target_addr_out(taddr),
    .set_clock_mode_runtime_out(ck), .clock_mode_out(cmode),
    .running_out(run), .pc_out(pc));
  clxu_hub_model hub (.sys_clk_in(clk), .hub_req_in(req), .hub_we_in(we),
    .hub_addr_in(addr), .hub_wdata_in(wdata), .wait_in(wcyc),
    .hub_ack_out(ack), .hub_rdata_out(rdata));
  // ************************
  // Monitor of hub writes and control pulses
  // ************************
  always @(posedge clk)
  begin
    if (req && we && ack && nw < 16)
    begin
      wa[nw] = addr;
      wd[nw] = wdata;
      nw = nw + 1;
    end
    if (ck)
      cap[0] = {24'h0, cmode};
    if (st)
      cap[1] = {13'h0, tcore, taddr};
    if (hl)
      cap[2] = {29'h0, tcore};
  end
  task report_and_stop;
  begin
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task ckw(input integer k, input [15:0] a, input [31:0] d);
  begin
    check({16'h0, wa[k]}, {16'h0, a});
    check(wd[k], d);
  end
  endtask
  task wait_for(input integer sel);
    integer n;
  begin
    n = 0;
    while (!(sel == 0 ? run === 1'b1 : sel == 1 ? run === 1'b0 :
      cap[2] === 32'h5))
    begin
      @(negedge clk);
      n = n + 1;
      if (n > 3000)
      begin
        mismatches = mismatches + 1;
        report_and_stop;
      end
    end
  end
  endtask
  task pulse(input sel);
  begin
    @(negedge clk);
    if (sel)
      halt = 1'b1;
    else
      launch = 1'b1;
    @(negedge clk);
    launch = 1'b0;
    halt = 1'b0;
  end
  endtask
  task p(input integer k, input [5:0] op, input wr, input imm,
    input [8:0] d, input [8:0] s);
  begin
    hub.mem[64 + k] = {op, 2'h0, wr, imm, 4'h0, d, s};
  end
  endtask
  task t_launch;
  begin
    pulse(1'b0);
    wait_for(0);
    check({23'h0, pc}, 32'h0);
  end
  endtask
  task t_program;
  begin
    wait_for(2);
    repeat (60) @(negedge clk);
    ckw(0, 16'h40, 32'h55);
    ckw(1, 16'h44, 32'h5);
    ckw(2, 16'h4C, 32'h1A5C);
    ckw(3, 16'h48, 32'h3);
    ckw(4, 16'h48, 32'h2);
    ckw(5, 16'h48, 32'h1);
    ckw(6, 16'h54, 32'hA3);
    ckw(7, 16'h58, 32'hEF);
    ckw(8, 16'h60, 32'hBEEF);
    ckw(9, 16'h64, 32'h50);
    ckw(10, 16'h69, 32'hA3);
    check(nw, 32'hB);
    check(cap[0], 32'h6A);
    check(cap[1], 32'h50200);
    check({23'h0, pc}, 32'h2D);
  end
  endtask
  task t_stop;
  begin
    pulse(1'b1);
    wait_for(1);
    check({31'h0, req}, 32'h0);
  end
  endtask
  task t_abort;
  begin
    wcyc = 2'h3;
    pulse(1'b0);
    repeat (20) @(negedge clk);
    pulse(1'b1);
    repeat (2) @(negedge clk);
    check({30'h0, req, run}, 32'h0);
  end
  endtask
  initial
  begin
    for (i = 0; i < 512; i = i + 1)
      hub.mem[64 + i] = 32'h0;
    p(0, `CLXU_OP_ADD, 1'b1, 1'b1, 9'h14, 9'h19);
    p(1, `CLXU_OP_ADD, 1'b1, 1'b0, 9'h14, 9'h15);
    p(2, `CLXU_OP_RDL, 1'b0, 1'b1, 9'h14, 9'h40);
    p(3, `CLXU_OP_HUB, 1'b1, 1'b1, 9'h16, 9'h1);
    p(4, `CLXU_OP_RDL, 1'b0, 1'b1, 9'h16, 9'h44);
    p(5, `CLXU_OP_RDL, 1'b0, 1'b1, 9'h1F0, 9'h4C);
    p(6, `CLXU_OP_RDL, 1'b0, 1'b1, 9'h18, 9'h48);
    p(7, `CLXU_OP_DJNZ, 1'b1, 1'b1, 9'h18, 9'h6);
    p(8, `CLXU_OP_JMP, 1'b0, 1'b0, 9'h0, 9'h19);
    p(9, `CLXU_OP_RDL, 1'b0, 1'b1, 9'h14, 9'h50);
    p(10, `CLXU_OP_HUB, 1'b0, 1'b1, 9'h17, 9'h0);
    p(11, `CLXU_OP_HUB, 1'b0, 1'b1, 9'h1A, 9'h2);
    p(12, `CLXU_OP_HUB, 1'b0, 1'b1, 9'h1A, 9'h3);
    p(13, `CLXU_OP_JMP, 1'b0, 1'b1, 9'h0, 9'h20);
    p(32, `CLXU_OP_SUB, 1'b1, 1'b1, 9'h14, 9'h5);
    p(33, `CLXU_OP_MOV, 1'b1, 1'b1, 9'h1B, 9'h1FF);
    p(34, `CLXU_OP_XOR, 1'b1, 1'b0, 9'h1B, 9'h14);
    p(35, `CLXU_OP_AND, 1'b1, 1'b1, 9'h1B, 9'hF0);
    p(36, `CLXU_OP_OR, 1'b1, 1'b1, 9'h1B, 9'h3);
    p(37, `CLXU_OP_RDB, 1'b1, 1'b1, 9'h1C, 9'h5C);
    p(38, `CLXU_OP_RDW, 1'b1, 1'b1, 9'h1D, 9'h5C);
    p(39, `CLXU_OP_RDL, 1'b0, 1'b1, 9'h1B, 9'h54);
    p(40, `CLXU_OP_RDL, 1'b0, 1'b1, 9'h1C, 9'h58);
    p(41, `CLXU_OP_RDL, 1'b0, 1'b1, 9'h1D, 9'h60);
    p(42, `CLXU_OP_RDL, 1'b0, 1'b1, 9'h14, 9'h64);
    p(43, `CLXU_OP_ADD, 1'b1, 1'b0, 9'h2C, 9'h1E);
    p(44, `CLXU_OP_RDL, 1'b0, 1'b1, 9'h1B, 9'h68);
    p(45, `CLXU_OP_JMP, 1'b0, 1'b1, 9'h0, 9'h2D);
    hub.mem[23] = 32'hDEADBEEF;
    hub.mem[94] = 32'h1;
    hub.mem[84] = 32'h32;
    hub.mem[85] = 32'hA;
    hub.mem[87] = 32'h6A;
    hub.mem[88] = 32'h3;
    hub.mem[89] = 32'hA;
    hub.mem[90] = 32'h2005;
    for (i = 0; i < 3; i = i + 1)
      cap[i] = 32'h0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_launch;
    t_program;
    t_stop;
    t_abort;
    report_and_stop;
  end
endmodule
